/* File: core/wdt_consts.vh */
// Constants for the watchdog timer unit: register map, fields, resets, codes
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define WDT_OFF_SELECT 12'h000
`define WDT_OFF_CONTROL 12'h004
`define WDT_OFF_STATUS 12'h008
`define WDT_OFF_IRQ_STATUS 12'h00c
`define WDT_OFF_IRQ_ENABLE 12'h010
`define WDT_OFF_IRQ_CLEAR 12'h014
`define WDT_OFF_CONFIG 12'h018

// ****************************************
// Field positions and widths
// ****************************************
`define WDT_SEL_LSB 0
`define WDT_SEL_MSB 2
`define WDT_EN_LSB 0
`define WDT_EN_MSB 3
`define WDT_ST_TIMEOUT 0
`define WDT_ST_POWERDOWN 1
`define WDT_ST_RUNNING 2
`define WDT_IRQ_TIMEOUT 0
`define WDT_IRQ_WAKE 1
`define WDT_IRQ_RESETREQ 2
`define WDT_IRQ_WIDTH 3

// ****************************************
// Reset values and codes
// ****************************************
`define WDT_SEL_RESET 3'h7
`define WDT_EN_OFF_CODE 4'ha
`define WDT_EN_RECOMMENDED 4'h5
`define WDT_SRC_INTOSC 2'h0
`define WDT_SRC_RTC 2'h1
`define WDT_SRC_SYSDIV4 2'h2

// ****************************************
// Timing counts
// ****************************************
`define WDT_DIV_WIDTH 8
`define WDT_PRE_WIDTH 7

`endif

/* File: core/wdt_unit.v */
// Watchdog timer unit with APB register access and interrupt status
`timescale 1ns/1ps
`include "wdt_consts.vh"

// Behaviour
// R1 - Watchdog runs if the fixed option or the register enable code enables it.
// R2 - Only enable code 1010B disables; any other written value enables.
// R3 - Enable code loads its disabling value at power-up.
// R4 - Software should write 0101B to enable, for best protection.
// R5 - With watchdog off, every kick instruction is a no-operation.
// R6 - Clock source fixed by option: internal osc, RTC osc or system clock/4.
// R7 - With system clock/4 selected, counting stops during power-down.
// R8 - Selected clock divides by 256 in 8 bits, then a 7-bit prescaler.
// R9 - Prescale select at bits 0 to 2; all set gives 1:128.
// R10 - Select value n up to 6 gives ratio 2 to the power n+1.
// R11 - Normal time-out requests a full device reset and sets time-out flag.
// R12 - Power-down time-out wakes device, sets flag, resets only PC and SP.
// R13 - A low external reset pin clears the watchdog count.
// R14 - The halt instruction clears the watchdog count.
// R15 - Single scheme: one single kick instruction clears the count.
// R16 - Dual scheme: the two distinct kicks must alternate to clear.
// R17 - Every clear returns both divider and prescaler to zero.
// R18 - On power-down entry clear, then keep counting on osc or RTC source.
// R19 - Halt sets power-down flag and clears time-out flag.
module wdt_unit (
  mclk,
  rst,
  clkEn,
  pselIn,
  penableIn,
  pwriteIn,
  paddrIn,
  pwdataIn,
  prdata,
  pready,
  pslverr,
  optEnable,
  optSource,
  optDualKick,
  intOscClk,
  rtcOscClk,
  resetPinN,
  singleKickInstr,
  firstHalfKickInstr,
  secondHalfKickInstr,
  haltInstr,
  instrTick,
  deviceResetReq,
  pcSpResetReq,
  wakeReq,
  irq
);
  input wire mclk;
  input wire rst;
  input wire clkEn;
  input wire pselIn;
  input wire penableIn;
  input wire pwriteIn;
  input wire [11:0] paddrIn;
  input wire [31:0] pwdataIn;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  input wire optEnable;
  input wire [1:0] optSource;
  input wire optDualKick;
  input wire intOscClk;
  input wire rtcOscClk;
  input wire resetPinN;
  input wire singleKickInstr;
  input wire firstHalfKickInstr;
  input wire secondHalfKickInstr;
  input wire haltInstr;
  input wire instrTick;
  output reg deviceResetReq;
  output reg pcSpResetReq;
  output reg wakeReq;
  output reg irq;

  // ****************************************
  // Functions
  // ****************************************
  // Prescaler terminal value for a select code: ratio 2^(n+1), so mask of n+1 ones.
  // The prescaler holds only 7 bits, so code 7 stays at 1:128 like code 6; a plain
  // shift would wrap there and collapse the period to its shortest.
  function [6:0] preLimit;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: preLimit = 7'h01; // [R10]
        3'h1: preLimit = 7'h03;
        3'h2: preLimit = 7'h07;
        3'h3: preLimit = 7'h0f;
        3'h4: preLimit = 7'h1f;
        3'h5: preLimit = 7'h3f;
        3'h6: preLimit = 7'h7f;
        default: preLimit = 7'h7f; // [R9]
      endcase
    end
  endfunction

  // Rising edge of a synchronised slow clock against its previous sample
  function riseOf;
    input cur;
    input prev;
    begin
      riseOf = cur & ~prev;
    end
  endfunction

  // Register hit: a bus address matches one register's byte offset
  function regHit;
    input [11:0] addr;
    input [11:0] off;
    begin
      regHit = (addr == off);
    end
  endfunction

  // ****************************************
  // Synchronisers for pins and foreign clocks
  // ****************************************
  reg [1:0] oscSync1_q;
  reg [1:0] oscSync2_q;
  reg [1:0] oscPrev_q;
  reg resetPinSync1_q;
  reg resetPinSync2_q;

  // Edge history is kept behind the second flop, so nothing reads a metastable stage
  // Two flops per asynchronous input; the first flop feeds only the second
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      oscSync1_q <= 2'h0;
      oscSync2_q <= 2'h0;
      oscPrev_q <= 2'h0;
      resetPinSync1_q <= 1'h1;
      resetPinSync2_q <= 1'h1;
    end else if (clkEn) begin
      oscSync1_q <= {rtcOscClk, intOscClk};
      oscSync2_q <= oscSync1_q;
      oscPrev_q <= oscSync2_q;
      resetPinSync1_q <= resetPinN;
      resetPinSync2_q <= resetPinSync1_q;
    end
  end

  // ****************************************
  // Registers and state
  // ****************************************
  reg [2:0] selReg_q;
  reg [3:0] enCode_q;
  reg timeoutFlag_q;
  reg powerdownFlag_q;
  reg [2:0] irqStatus_q;
  reg [2:0] irqEnable_q;
  reg [7:0] divCount_q;
  reg [6:0] preCount_q;
  reg lastKickSecond_q;
  reg lastKickValid_q;

  wire wdtOn;
  wire wdtTick;
  wire kickClear;
  wire anyClear;
  wire timeout;
  wire apbWrite;
  wire apbRead;
  wire validAddr;
  wire oscRise;
  wire rtcRise;
  wire wrSelect;
  wire wrControl;
  wire wrIrqEnable;
  wire wrIrqClear;
  wire [2:0] irqEvents;

  // Either enable source turns the watchdog on; only code 1010B is off
  assign wdtOn = optEnable | (enCode_q != `WDT_EN_OFF_CODE); // [R1] [R2]

  // Edge detect on each slow source after its synchroniser
  assign oscRise = riseOf(oscSync2_q[0], oscPrev_q[0]); // [R6]
  assign rtcRise = riseOf(oscSync2_q[1], oscPrev_q[1]);

  // Source pick; system clock/4 is the instruction tick, halted in power-down
  assign wdtTick = (optSource == `WDT_SRC_INTOSC) ? oscRise :
                   (optSource == `WDT_SRC_RTC) ? rtcRise :
                   (instrTick & ~powerdownFlag_q); // [R6] [R7]

  // Kick decoding: single scheme or alternating dual scheme, no-op when off
  assign kickClear = wdtOn & (optDualKick ?
    ((firstHalfKickInstr & lastKickValid_q & lastKickSecond_q) |
     (secondHalfKickInstr & lastKickValid_q & ~lastKickSecond_q)) :
    singleKickInstr); // [R5] [R15] [R16]

  // All clear causes restart the full period
  assign anyClear = kickClear | haltInstr | ~resetPinSync2_q; // [R13] [R14] [R17]

  assign timeout = wdtOn & wdtTick & (divCount_q == 8'hff) &
                   (preCount_q == preLimit(selReg_q)); // [R8]

  assign apbWrite = pselIn & penableIn & pwriteIn & ~pready;
  assign apbRead = pselIn & penableIn & ~pwriteIn & ~pready;
  assign validAddr = (paddrIn == `WDT_OFF_SELECT) | (paddrIn == `WDT_OFF_CONTROL) |
                     (paddrIn == `WDT_OFF_STATUS) | (paddrIn == `WDT_OFF_IRQ_STATUS) |
                     (paddrIn == `WDT_OFF_IRQ_ENABLE) | (paddrIn == `WDT_OFF_IRQ_CLEAR) |
                     (paddrIn == `WDT_OFF_CONFIG);

  // Write strobes per register, taken on the first access edge only
  assign wrSelect = apbWrite & regHit(paddrIn, `WDT_OFF_SELECT);
  assign wrControl = apbWrite & regHit(paddrIn, `WDT_OFF_CONTROL);
  assign wrIrqEnable = apbWrite & regHit(paddrIn, `WDT_OFF_IRQ_ENABLE);
  assign wrIrqClear = apbWrite & regHit(paddrIn, `WDT_OFF_IRQ_CLEAR);

  // Sticky sources {device reset request, wake, any time-out}
  assign irqEvents = {timeout & ~powerdownFlag_q, timeout & powerdownFlag_q, timeout};

  // ****************************************
  // Count path
  // ****************************************
  // Divide by 256 then by the prescaler; clears win over counting
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCount_q <= 8'h00;
      preCount_q <= 7'h00;
    end else if (clkEn) begin
      if (anyClear || !wdtOn || timeout) begin
        divCount_q <= 8'h00; // [R17] [R18]
        preCount_q <= 7'h00;
      end else if (wdtTick) begin
        divCount_q <= divCount_q + 8'h01; // [R8]
        if (divCount_q == 8'hff) begin
          preCount_q <= preCount_q + 7'h01;
        end
      end
    end
  end

  // Dual-kick history: only the opposite half may clear next
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      lastKickValid_q <= 1'b0;
      lastKickSecond_q <= 1'b0;
    end else if (clkEn && wdtOn && optDualKick) begin
      if (firstHalfKickInstr) begin
        lastKickValid_q <= 1'b1;
        lastKickSecond_q <= 1'b0; // [R16]
      end else if (secondHalfKickInstr) begin
        lastKickValid_q <= 1'b1;
        lastKickSecond_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Status flags and outcome pulses
  // ****************************************
  // Time-out set wins over the halt clear in the same cycle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      timeoutFlag_q <= 1'b0;
      powerdownFlag_q <= 1'b0;
      deviceResetReq <= 1'b0;
      pcSpResetReq <= 1'b0;
      wakeReq <= 1'b0;
    end else if (clkEn) begin
      deviceResetReq <= timeout & ~powerdownFlag_q; // [R11]
      pcSpResetReq <= timeout & powerdownFlag_q; // [R12]
      wakeReq <= timeout & powerdownFlag_q; // [R12]
      if (timeout) begin
        timeoutFlag_q <= 1'b1; // [R11] [R12]
      end else if (haltInstr) begin
        timeoutFlag_q <= 1'b0; // [R19]
      end
      if (haltInstr) begin
        powerdownFlag_q <= 1'b1; // [R19]
      end else if (kickClear || (timeout && powerdownFlag_q)) begin
        powerdownFlag_q <= 1'b0; // Wake ends power-down; kicks clear the flag
      end
    end
  end

  // ****************************************
  // APB slave and interrupt logic
  // ****************************************
  // Writable registers; a write to an unmapped or read-only offset changes nothing
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      selReg_q <= `WDT_SEL_RESET;
      enCode_q <= `WDT_EN_OFF_CODE; // [R3]
      irqEnable_q <= 3'h0;
    end else if (clkEn) begin
      if (wrSelect) begin
        selReg_q <= pwdataIn[`WDT_SEL_MSB:`WDT_SEL_LSB]; // [R9]
      end
      if (wrControl) begin
        enCode_q <= pwdataIn[`WDT_EN_MSB:`WDT_EN_LSB]; // [R2] [R4]
      end
      if (wrIrqEnable) begin
        irqEnable_q <= pwdataIn[2:0];
      end
    end
  end

  // Sticky events: set wins over a clear written in the same cycle, so no
  // time-out is lost to a clear that races it
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqStatus_q <= 3'h0;
      irq <= 1'b0;
    end else if (clkEn) begin
      if (wrIrqClear) begin
        irqStatus_q <= (irqStatus_q & ~pwdataIn[2:0]) | irqEvents;
      end else begin
        irqStatus_q <= irqStatus_q | irqEvents;
      end
      irq <= |(irqStatus_q & irqEnable_q); // Level, one cycle behind the status
    end
  end

  // One wait state: pready pulses in the second access cycle
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready <= pselIn & penableIn & ~pready;
      pslverr <= pselIn & penableIn & ~pready & ~validAddr;
      prdata <= 32'h0;
      if (apbRead) begin
        case (paddrIn)
          `WDT_OFF_SELECT: prdata <= {29'h0, selReg_q};
          `WDT_OFF_CONTROL: prdata <= {28'h0, enCode_q};
          `WDT_OFF_STATUS: prdata <= {29'h0, wdtOn, powerdownFlag_q, timeoutFlag_q};
          `WDT_OFF_IRQ_STATUS: prdata <= {29'h0, irqStatus_q};
          `WDT_OFF_IRQ_ENABLE: prdata <= {29'h0, irqEnable_q};
          `WDT_OFF_CONFIG: prdata <= {28'h0, optDualKick, optSource, optEnable};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

endmodule

/* File: tb/wdt_unit_chk.sv */
// Checker of bus handshake and watchdog output pulse timing
`timescale 1ns/1ps
// ****************
// Checker
// ****************
module wdt_unit_chk (
  input wire mclk,
  input wire rst,
  input wire clkEn,
  input wire pselIn,
  input wire penableIn,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire resetPinN,
  input wire haltInstr,
  input wire deviceResetReq,
  input wire pcSpResetReq,
  input wire wakeReq
);
  default clocking cb @(posedge mclk); endclocking
  // A low clock enable freezes every output, so timing claims pause with it
  default disable iff (rst || !clkEn);
  // First access cycle of a transfer
  sequence sAcc;
    pselIn && penableIn && !pready;
  endsequence
  // Pin low long enough to pass the synchroniser
  sequence sPinLow;
    !resetPinN [*5];
  endsequence
  chk_ready_wait: assert property (sAcc |=> pready) else $error("pready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata idle");
  chk_reset_once: assert property (
    deviceResetReq |=> !deviceResetReq) else $error("reset request too long");
  chk_wake_pair: assert property (
    (wakeReq || pcSpResetReq) |-> wakeReq && pcSpResetReq && !deviceResetReq)
    else $error("wake without pc reset");
  chk_pin_clear: assert property (
    sPinLow |-> !deviceResetReq && !wakeReq) else $error("time-out with pin low");
  chk_halt_clear: assert property (
    haltInstr |=> (!deviceResetReq && !wakeReq) [*8]) else $error("time-out after halt");
endmodule

bind wdt_unit wdt_unit_chk i_wdt_unit_chk (.*);

/* File: tb/watchdog_timer_unit_tb.sv */
// Self-checking bench of the watchdog timer unit
`timescale 1ns/1ps
module watchdog_timer_unit_tb;
  reg mclk = 0, rst = 1, clkEn = 1, pselIn = 0, penableIn = 0, pwriteIn = 0, err;
  reg optEnable = 0, optDualKick = 0, resetPinN = 1, instrTick = 0, haltInstr = 0;
  reg singleKickInstr = 0, firstHalfKickInstr = 0, secondHalfKickInstr = 0;
  reg [11:0] paddrIn = 12'h0;
  reg [31:0] pwdataIn = 32'h0, rd;
  reg [1:0] optSource = 2'h2;
  reg [2:0] dv = 3'h0;
  reg [44:0] rows [0:5];
  wire intOscClk = dv[1], rtcOscClk = dv[2];
  wire [31:0] prdata;
  wire pready, pslverr, deviceResetReq, pcSpResetReq, wakeReq, irq;
  int n_mismatch = 0, num_checks = 0, c, i;

  wdt_unit i_wdt_unit (.*);

  // Clock, and slow sources derived from it so they stay edge aligned
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    instrTick <= ~instrTick;
    dv <= dv + 3'h1;
  end

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready however long it takes
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge mclk);
    pselIn <= 1'b1;
    pwriteIn <= w;
    paddrIn <= a;
    pwdataIn <= d;
    @(posedge mclk);
    penableIn <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    pselIn <= 1'b0;
    penableIn <= 1'b0;
  endtask

  // One-cycle pulse on {halt, second, first, single}
  task kick(input [3:0] m);
    @(posedge mclk);
    {haltInstr, secondHalfKickInstr, firstHalfKickInstr, singleKickInstr} <= m;
    @(posedge mclk);
    {haltInstr, secondHalfKickInstr, firstHalfKickInstr, singleKickInstr} <= 4'h0;
  endtask

  // Cycles until a time-out pulse, capped at lim; one edge always passes first
  // so the pulse that ended the previous wait is not counted again
  task meas(input int lim);
    c = 0;
    do begin
      @(posedge mclk);
      c++;
    end while (deviceResetReq !== 1'b1 && wakeReq !== 1'b1 && c < lim);
  endtask

  initial begin
    #1000000;
    n_mismatch++;
    finish_test;
  end

  initial begin
    // Address, read data, error
    rows[0] = {12'h000, 32'h7, 1'b0};
    rows[1] = {12'h004, 32'ha, 1'b0};
    rows[2] = {12'h008, 32'h0, 1'b0};
    rows[3] = {12'h00c, 32'h0, 1'b0};
    rows[4] = {12'h018, 32'h4, 1'b0};
    rows[5] = {12'h020, 32'h0, 1'b1};
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      apb(1'b0, rows[i][44:33], 32'h0);
      chk(rd, rows[i][32:1], "rdata");
      chk(err, rows[i][0], "slverr");
    end
    // Both enables off: kicks ignored, no time-out
    kick(4'h1);
    meas(1200);
    chk(c, 1200, "off");
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0, "status");
    // Ratio 1:2 on the instruction tick gives 512 ticks
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h3);
    meas(1200);
    chk(c > 1014 && c < 1030, 1, "period");
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h5, "status");
    apb(1'b0, 12'h00c, 32'h5);
    chk(rd, 32'h5, "irqstat");
    apb(1'b1, 12'h010, 32'h1);
    repeat (2) @(posedge mclk);
    chk(irq, 1, "irq");
    apb(1'b1, 12'h014, 32'h7);
    repeat (2) @(posedge mclk);
    chk(irq, 0, "irqclr");
    // A kick in mid-period restarts the whole period
    repeat (500) @(posedge mclk);
    kick(4'h1);
    meas(1200);
    chk(c > 1014 && c < 1030, 1, "kick");
    // Dual scheme: alternate clears, a repeat does not
    optDualKick <= 1'b1;
    repeat (300) @(posedge mclk);
    kick(4'h2);
    kick(4'h4);
    meas(1200);
    chk(c > 1014 && c < 1030, 1, "dual");
    repeat (300) @(posedge mclk);
    kick(4'h4);
    meas(1200);
    chk(c > 710 && c < 735, 1, "repeat");
    // Fixed option alone enables
    optDualKick <= 1'b0;
    apb(1'b1, 12'h004, 32'ha);
    optEnable <= 1'b1;
    meas(1200);
    chk(c > 1014 && c < 1030, 1, "option");
    resetPinN <= 1'b0;
    meas(1200);
    chk(c, 1200, "pin");
    resetPinN <= 1'b1;
    // Halt on the instruction tick: the count stands still in power-down
    kick(4'h8);
    meas(1200);
    chk(c, 1200, "pdstop");
    // Halt, then wake from the internal oscillator, 4 cycles a tick
    apb(1'b1, 12'h004, 32'h5);
    optSource <= 2'h0;
    kick(4'h8);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h6, "halt");
    meas(2200);
    chk(wakeReq, 1, "wake");
    chk(c > 2026 && c < 2062, 1, "pdtime");
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h5, "woken");
    // Clock enable low for 1000 cycles stretches the period by as much
    kick(4'h1);
    clkEn <= 1'b0;
    repeat (1000) @(posedge mclk);
    clkEn <= 1'b1;
    meas(2200);
    chk(c > 2026 && c < 2062, 1, "freeze");
    // Reset in mid-run: outputs drop, registers return to their reset values
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({deviceResetReq, wakeReq, pcSpResetReq, irq, pready}, 0, "rstout");
    rst <= 1'b0;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'ha, "rstctl");
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h7, "rstsel");
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h4, "rststat");
    finish_test;
  end
endmodule
